// *** shared/sbi_defines.vh ***
// constants for the two-wire serial bus handshake block
`ifndef SBI_DEFINES_VH
`define SBI_DEFINES_VH

// control register bit positions
`define CTL_BUSY_SYNC_EN 3'd7
`define CTL_ACK_DETECT 3'd6
`define CTL_ACK_AUTO_EN 3'd5
`define CTL_ACK_TRIGGER 3'd4
`define CTL_CMD_DETECT 3'd3
`define CTL_REL_DETECT 3'd2
`define CTL_CMD_TRIGGER 3'd1
`define CTL_REL_TRIGGER 3'd0
`define CTL_RESET 8'h00

// interrupt timing select register
`define TIM_CLOCK_LINE_LEVEL 3'd6
`define TIM_RELEASE_IRQ_SEL 3'd5
`define TIM_RESET 8'h00
`define TIM_WRITE_MASK 8'hbf

// bit count of one byte and of the interrupt edge
`define BITS_PER_BYTE 4'd8
`define IRQ_RISE_COUNT 4'd9

// shift register reset value, line released
`define SHIFT_RESET 8'hff

`endif

// *** hdl/byte_fifo.v ***
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire mclk,
  input wire rstn,
  input wire flush,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_push;
  wire do_pop;
  integer i;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign do_push = in_valid & in_ready;
  assign do_pop = out_valid & out_ready;

  always @* begin
    out_data = mem[rd_ptr];
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
    end else if (flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_push & ~do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop & ~do_push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** hdl/serial_bus_handshake_control.v ***
// handshake, bus conditions and shifting for the two-wire serial bus mode
`timescale 1ns/1ps
`default_nettype none
`include "sbi_defines.vh"

// How it works
// - auto off: acknowledge only on software trigger
// - auto on: acknowledge at falling edge after byte
// - late auto set: acknowledge next falling, stays set
// - ack flag cleared after start, disable, reset
// - low line at rising after byte sets ack
// - busy enable cleared, fifo not full: line ready next falling
// - busy driven from falling edge after acknowledge
// - new transfer ends busy, enable bit kept
// - timing register resets zero, bit/byte writes
// - clock level bit read-only, zero when disabled
// - data rises, clock high: release, clear command
// - data falls, clock high: command detected
// - receiver holds line low one clock period
// - busy slave holds line low after acknowledge
// - line released high before and after transfer
// - ninth rising edge raises transfer interrupt
// - msb first out on falling, sample rising
// - release trigger sets latch, command clears it
module serial_bus_handshake_control #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
) (
  input wire mclk,
  input wire rstn,
  input wire channel_enable,
  input wire wakeup_match_en,
  input wire serial_clock_pin,
  input wire serial_data_line_a_in,
  output wire serial_data_line_a_out,
  output wire serial_data_line_a_oe,
  input wire [7:0] wdata,
  input wire [2:0] bit_sel,
  input wire bit_val,
  input wire ctrl_wr_byte,
  input wire ctrl_wr_bit,
  output wire [7:0] ctrl_rdata,
  input wire timing_wr_byte,
  input wire timing_wr_bit,
  output wire [7:0] timing_rdata,
  input wire shift_wr,
  output wire [7:0] shift_rdata,
  output reg transfer_irq_flag,
  output wire [7:0] rx_data,
  output wire rx_valid,
  input wire rx_ready
);
  localparam S_IDLE = 3'd0;
  localparam S_DATA = 3'd1;
  localparam S_DONE = 3'd2;
  localparam S_ACK = 3'd3;
  localparam S_POST = 3'd4;

  // byte or single-bit write applied to a register image
  function [7:0] merge_write;
    input [7:0] old;
    input wr_byte;
    input wr_bit;
    input [2:0] sel;
    input val;
    input [7:0] data;
    reg [7:0] res;
    begin
      res = old;
      if (wr_byte) begin
        res = data;
      end else if (wr_bit) begin
        res[sel] = val;
      end
      merge_write = res;
    end
  endfunction

  reg sclk_s1;
  reg sclk_s2;
  reg sclk_d;
  reg sda_s1;
  reg sda_s2;
  reg sda_d;
  reg [2:0] state;
  reg [3:0] rise_cnt;
  reg [7:0] shift_register;
  reg out_latch;
  reg out_released;
  reg ack_drive;
  reg busy_drive;
  reg ack_clr_pend;
  reg busy_sync_en;
  reg ack_auto_en;
  reg ack_trigger;
  reg ack_detect_flag;
  reg release_detect_flag;
  reg command_detect_flag;
  reg [7:0] timing_reg;
  reg push_valid;
  reg [7:0] push_data;
  wire push_ready;
  wire sclk_rise;
  wire sclk_fall;
  wire sda_rise;
  wire sda_fall;
  wire clock_high;
  wire busy_req;
  wire [7:0] ctrl_view;
  wire [7:0] ctrl_new;
  wire ctrl_wr;
  wire [7:0] next_timing;

  // clock and data are foreign to mclk, two flops before use
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      sclk_s1 <= serial_clock_pin;
      sclk_s2 <= sclk_s1;
      sclk_d <= sclk_s2;
      sda_s1 <= serial_data_line_a_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  assign sclk_rise = sclk_s2 & ~sclk_d;
  assign sclk_fall = ~sclk_s2 & sclk_d;
  // clock must be high on both samples so a clock edge is not taken as a condition
  assign clock_high = sclk_s2 & sclk_d;
  assign sda_rise = sda_s2 & ~sda_d;
  assign sda_fall = ~sda_s2 & sda_d;

  // a full fifo keeps the slave busy, so the master is stalled instead of losing bytes
  assign busy_req = busy_sync_en | ~push_ready;

  // trigger bits always read back as zero
  assign ctrl_view = {busy_sync_en, ack_detect_flag, ack_auto_en, 1'b0,
                      command_detect_flag, release_detect_flag, 2'b00};
  assign ctrl_wr = ctrl_wr_byte | ctrl_wr_bit;
  assign ctrl_new = merge_write(ctrl_view, ctrl_wr_byte, ctrl_wr_bit, bit_sel, bit_val, wdata);
  assign ctrl_rdata = ctrl_view;

  assign next_timing = merge_write(timing_reg, timing_wr_byte, timing_wr_bit,
                                   bit_sel, bit_val, wdata) & `TIM_WRITE_MASK;
  assign timing_rdata = {timing_reg[7],
                         sclk_s2 & channel_enable,
                         timing_reg[5:0]};
  assign shift_rdata = shift_register;

  // open-drain: only ever pull low; wake-up mode masks the shifted data and command pull, but not the ack or busy pull
  assign serial_data_line_a_out = 1'b0;
  assign serial_data_line_a_oe = channel_enable &
                                 (ack_drive | busy_drive |
                                  (~out_latch & ~wakeup_match_en));

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      timing_reg <= `TIM_RESET;
    end else if (timing_wr_byte | timing_wr_bit) begin
      timing_reg <= next_timing;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= S_IDLE;
      rise_cnt <= 4'd0;
      shift_register <= `SHIFT_RESET;
      out_latch <= 1'b1;
      out_released <= 1'b0;
      ack_drive <= 1'b0;
      busy_drive <= 1'b0;
      ack_clr_pend <= 1'b0;
      busy_sync_en <= 1'b0;
      ack_auto_en <= 1'b0;
      ack_trigger <= 1'b0;
      ack_detect_flag <= 1'b0;
      release_detect_flag <= 1'b0;
      command_detect_flag <= 1'b0;
      transfer_irq_flag <= 1'b0;
      push_valid <= 1'b0;
      push_data <= 8'h00;
    end else if (!channel_enable) begin
      state <= S_IDLE;
      rise_cnt <= 4'd0;
      out_latch <= 1'b1;
      out_released <= 1'b0;
      ack_drive <= 1'b0;
      busy_drive <= 1'b0;
      ack_clr_pend <= 1'b0;
      ack_trigger <= 1'b0;
      ack_detect_flag <= 1'b0;
      release_detect_flag <= 1'b0;
      command_detect_flag <= 1'b0;
      transfer_irq_flag <= 1'b0;
      push_valid <= 1'b0;
      if (ctrl_wr) begin
        busy_sync_en <= ctrl_new[`CTL_BUSY_SYNC_EN];
        ack_auto_en <= ctrl_new[`CTL_ACK_AUTO_EN];
      end
    end else begin
      transfer_irq_flag <= 1'b0;
      push_valid <= 1'b0;

      if (ctrl_wr) begin
        busy_sync_en <= ctrl_new[`CTL_BUSY_SYNC_EN];
        ack_auto_en <= ctrl_new[`CTL_ACK_AUTO_EN];
        if (ctrl_new[`CTL_ACK_TRIGGER]) begin
          ack_trigger <= 1'b1;
        end
        // release and command triggers act at once; the ack trigger is stored until the next falling edge in S_DONE
        if (ctrl_new[`CTL_REL_TRIGGER]) begin
          out_latch <= 1'b1;
        end else if (ctrl_new[`CTL_CMD_TRIGGER]) begin
          out_latch <= 1'b0;
        end
      end

      case (state)
        S_DATA: begin
          if (sclk_fall && rise_cnt < `BITS_PER_BYTE) begin
            out_latch <= shift_register[7];
          end
          if (sclk_rise) begin
            shift_register <= {shift_register[6:0], sda_s2};
            if (rise_cnt == `BITS_PER_BYTE - 4'd1) begin
              state <= S_DONE;
              push_valid <= 1'b1;
              push_data <= {shift_register[6:0], sda_s2};
            end
          end
        end
        S_DONE: begin
          if (sclk_fall) begin
            if (!out_released) begin
              out_latch <= 1'b1;
              out_released <= 1'b1;
            end
            // auto covers both set-before and set-after completion
            if (ack_auto_en || ack_trigger) begin
              ack_drive <= 1'b1;
              ack_trigger <= 1'b0;
              state <= S_ACK;
            end
          end
        end
        S_ACK: begin
          if (sclk_fall) begin
            ack_drive <= 1'b0;
            busy_drive <= busy_req;
            state <= S_POST;
          end
        end
        default: begin
          if (sclk_fall && busy_drive && !busy_req) begin
            busy_drive <= 1'b0;
          end
        end
      endcase

      if (sclk_rise && rise_cnt != `IRQ_RISE_COUNT && state != S_IDLE) begin
        rise_cnt <= rise_cnt + 4'd1;
        if (rise_cnt == `BITS_PER_BYTE && !wakeup_match_en) begin
          transfer_irq_flag <= 1'b1;
        end
      end

      if (sclk_fall && ack_clr_pend) begin
        ack_clr_pend <= 1'b0;
        ack_detect_flag <= 1'b0;
      end

      // writing the shift register starts a byte and leaves busy
      if (shift_wr && !wakeup_match_en) begin
        shift_register <= wdata;
        state <= S_DATA;
        rise_cnt <= 4'd0;
        out_released <= 1'b0;
        ack_drive <= 1'b0;
        busy_drive <= 1'b0;
        ack_trigger <= 1'b0;
        ack_clr_pend <= 1'b1;
        release_detect_flag <= 1'b0;
        command_detect_flag <= 1'b0;
      end

      // sets come last so an event beats a clear in the same cycle
      if (sclk_rise && !sda_s2 &&
          (state == S_DONE || state == S_ACK || state == S_POST)) begin
        ack_detect_flag <= 1'b1;
      end
      if (clock_high && sda_rise) begin
        release_detect_flag <= 1'b1;
        command_detect_flag <= 1'b0;
        if (timing_reg[`TIM_RELEASE_IRQ_SEL]) begin
          transfer_irq_flag <= 1'b1;
        end
      end else if (clock_high && sda_fall) begin
        command_detect_flag <= 1'b1;
      end
    end
  end

  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) rx_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .flush(~channel_enable),
    .in_data(push_data),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );
endmodule
`default_nettype wire

// *** bench/master_model.sv ***
// bus master model: serial clock and open-drain pull on the data line
`timescale 1ns/1ps
`default_nettype none
module master_model (
  output logic sclk,
  output logic pull_low,
  input wire logic sda
);
  // clock stands high between frames, line released to the pull-up
  initial begin
    sclk = 1'b1;
    pull_low = 1'b0;
  end
  // data moves only while clock is low, sampled late in the high phase
  task automatic tick(input logic d, output logic seen);
    sclk = 1'b0;
    pull_low = ~d;
    #100;
    sclk = 1'b1;
    #90;
    seen = sda;
    #10;
  endtask
  task automatic bits(input logic [7:0] d, input int n, output logic [7:0] q);
    logic b;
    for (int i = 0; i < n; i++) begin
      tick(d[7 - i], b);
      q = {q[6:0], b};
    end
  endtask
  // line edge with clock high: rise is release, fall is command
  task automatic cond(input logic rise);
    sclk = 1'b0;
    pull_low = rise;
    #100;
    sclk = 1'b1;
    #100;
    pull_low = ~rise;
    #250;
  endtask
endmodule
`default_nettype wire

// *** bench/sbi_props_props.sv ***
// port-level checks for the serial bus handshake block
`timescale 1ns/1ps
`default_nettype none
module sbi_props (
  input wire mclk,
  input wire rstn,
  input wire channel_enable,
  input wire wakeup_match_en,
  input wire serial_clock_pin,
  input wire serial_data_line_a_in,
  input wire serial_data_line_a_oe,
  input wire [7:0] wdata,
  input wire ctrl_wr_byte,
  input wire [7:0] ctrl_rdata,
  input wire timing_wr_byte,
  input wire [7:0] timing_rdata,
  input wire transfer_irq_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // eight samples of clock high cover the input synchroniser delay
  sequence rise_s;
    channel_enable && serial_clock_pin && !serial_data_line_a_in
    ##1 (channel_enable && serial_clock_pin && serial_data_line_a_in) [*8];
  endsequence
  sequence fall_s;
    channel_enable && serial_clock_pin && serial_data_line_a_in
    ##1 (channel_enable && serial_clock_pin && !serial_data_line_a_in) [*8];
  endsequence
  rel_det_a: assert property (rise_s |-> ##[0:3] (ctrl_rdata[2] && !ctrl_rdata[3]))
    else $error("release not flagged");
  cmd_det_a: assert property (fall_s |-> ##[0:3] ctrl_rdata[3])
    else $error("command not flagged");
  trig_zero_a: assert property (ctrl_rdata[4] == 1'b0 && ctrl_rdata[1:0] == 2'b00)
    else $error("trigger bit reads one");
  clk_level_a: assert property (!channel_enable |-> !timing_rdata[6])
    else $error("clock level not zero");
  off_clear_a: assert property (!channel_enable ##1 !channel_enable |-> ctrl_rdata[6] == 1'b0 && ctrl_rdata[3:2] == 2'b00)
    else $error("flags kept while off");
  tim_write_a: assert property (timing_wr_byte |=> timing_rdata[7] == $past(wdata[7]) && timing_rdata[5:0] == $past(wdata[5:0]))
    else $error("timing write lost");
  enab_keep_a: assert property (ctrl_wr_byte |=> ctrl_rdata[7] == $past(wdata[7]) && ctrl_rdata[5] == $past(wdata[5]))
    else $error("enable bits lost");
  cmd_trig_a: assert property (ctrl_wr_byte && wdata[1:0] == 2'b10 && channel_enable && !wakeup_match_en |-> ##[1:2] serial_data_line_a_oe)
    else $error("command trigger no pull");
  irq_pulse_a: assert property (transfer_irq_flag |=> !transfer_irq_flag)
    else $error("irq longer than a cycle");
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the serial bus handshake block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk, rstn, en, wc, wcb, wt, wtb, sw, rx_ready, bv, a, wk;
  logic [2:0] bs;
  logic [7:0] wdata, q;
  wire [7:0] crd, trd, srd, rxd;
  wire sclk, low, oe, dout, irq, rxv;
  wire sda = ~(oe | low);
  int num_errors, checks_done, cyc, irqs;
  master_model m_u (.sclk(sclk), .pull_low(low), .sda(sda));
  serial_bus_handshake_control dut_u (.mclk(mclk), .rstn(rstn), .channel_enable(en),
    .wakeup_match_en(wk), .serial_clock_pin(sclk), .serial_data_line_a_in(sda),
    .serial_data_line_a_out(dout), .serial_data_line_a_oe(oe), .wdata(wdata), .bit_sel(bs),
    .bit_val(bv), .ctrl_wr_byte(wc), .ctrl_wr_bit(wcb), .ctrl_rdata(crd), .timing_wr_byte(wt),
    .timing_wr_bit(wtb), .timing_rdata(trd), .shift_wr(sw), .shift_rdata(srd),
    .transfer_irq_flag(irq), .rx_data(rxd), .rx_valid(rxv), .rx_ready(rx_ready));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // cycle ceiling well above the under one thousand cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (irq === 1'b1) irqs++;
    if (cyc == 5000) begin
      num_errors++;
      print_verdict;
    end
  end
  task chk(input logic [7:0] e, input logic [7:0] g, input string w);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  // k: 0 ctrl byte, 1 timing byte, 2 shift, 3 timing bit, 4 ctrl bit {val, sel}
  task wr(input int k, input logic [7:0] d);
    @(posedge mclk);
    #1;
    wdata = d;
    bs = d[2:0];
    bv = d[3];
    {wc, wt, sw, wtb, wcb} = {k == 0, k == 1, k == 2, k == 3, k == 4};
    @(posedge mclk);
    #1;
    {wc, wt, sw, wtb, wcb} = 5'h00;
    @(posedge mclk);
    #1;
  endtask
  task pop(input logic [7:0] e);
    for (int n = 0; n < 50 && rxv !== 1'b1; n++) @(posedge mclk);
    #1;
    chk(e, rxd, "rx_data");
    rx_ready = 1'b1;
    @(posedge mclk);
    #1;
    rx_ready = 1'b0;
  endtask
  task t_regs;
    chk(8'h00, {7'h00, dout}, "line out level");
    chk(8'h00, crd, "ctrl");
    chk(8'h00, trd, "timing");
    chk(8'hff, srd, "shift");
    wr(1, 8'hff);
    chk(8'hbf, trd, "timing");
    en = 1'b1;
    wr(1, 8'h00);
    chk(8'h40, trd, "timing");
    wr(3, 8'h0d);
    chk(8'h60, trd, "timing bit");
    wr(3, 8'h05);
    chk(8'h40, trd, "timing bit");
    // wake-up keeps the data output off and ignores shift writes
    wk = 1'b1;
    wr(0, 8'h02);
    chk(8'h00, {7'h00, oe}, "wake off");
    wr(2, 8'h00);
    chk(8'hff, srd, "wake shift");
    wr(0, 8'h01);
    wk = 1'b0;
    $display("end regs");
  endtask
  task t_cond;
    m_u.cond(1'b1);
    chk(8'h04, crd, "flags");
    m_u.cond(1'b0);
    chk(8'h0c, crd, "flags");
    $display("end cond");
  endtask
  task t_tx;
    wr(0, 8'h02);
    chk(8'h01, {7'h00, oe}, "oe");
    wr(4, 8'h08);
    chk(8'h00, {7'h00, oe}, "oe");
    wr(2, 8'h96);
    m_u.bits(8'hff, 8, q);
    m_u.tick(1'b1, a);
    chk(8'h96, q, "sent");
    chk(8'h01, {7'h00, a}, "no ack");
    chk(8'h00, crd, "flags");
    pop(8'h96);
    wr(0, 8'h20);
    m_u.tick(1'b1, a);
    chk(8'h00, {7'h00, a}, "late ack");
    chk(8'h60, crd, "ctrl");
    // finish the acknowledge bit so the line is released with the clock low
    m_u.tick(1'b1, a);
    chk(8'h01, {7'h00, a}, "ack end");
    wr(0, 8'h00);
    wr(2, 8'hff);
    m_u.bits(8'h5a, 8, q);
    m_u.tick(1'b1, a);
    chk(8'h01, {7'h00, a}, "no auto ack");
    pop(8'h5a);
    wr(0, 8'h10);
    chk(8'h00, crd, "trigger reads zero");
    m_u.tick(1'b1, a);
    chk(8'h00, {7'h00, a}, "trig ack");
    chk(8'h40, crd, "ctrl");
    m_u.tick(1'b1, a);
    chk(8'h01, {7'h00, a}, "ack end");
    $display("end tx");
  endtask
  task t_busy;
    wr(0, 8'ha0);
    wr(2, 8'hff);
    m_u.bits(8'ha5, 1, q);
    chk(8'ha0, crd, "ack clear");
    m_u.bits(8'h4a, 7, q);
    m_u.tick(1'b1, a);
    chk(8'h00, {7'h00, a}, "ack");
    chk(8'he0, crd, "ctrl");
    chk(8'ha5, srd, "shift");
    pop(8'ha5);
    m_u.tick(1'b1, a);
    chk(8'h00, {7'h00, a}, "busy");
    wr(2, 8'hff);
    chk(8'h00, {7'h00, oe}, "busy end");
    chk(8'h80, crd & 8'h80, "busy bit");
    m_u.bits(8'h3c, 8, q);
    m_u.tick(1'b1, a);
    pop(8'h3c);
    m_u.tick(1'b1, a);
    wr(0, 8'h20);
    m_u.tick(1'b1, a);
    chk(8'h01, {7'h00, a}, "ready");
    $display("end busy");
  endtask
  task t_fifo;
    for (int i = 0; i < 4; i++) begin
      wr(2, 8'hff);
      m_u.bits(8'hc0 | i[7:0], 8, q);
      m_u.tick(1'b1, a);
    end
    m_u.tick(1'b1, a);
    chk(8'h00, {7'h00, a}, "full busy");
    for (int i = 0; i < 4; i++) pop(8'hc0 | i[7:0]);
    chk(8'h00, {7'h00, rxv}, "drained");
    en = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk(8'h00, {7'h00, oe}, "released");
    chk(8'h20, crd, "ctrl off");
    chk(8'h00, trd & 8'h40, "clock level");
    chk(8'h08, irqs[7:0], "irq count");
    $display("end fifo");
  endtask
  initial begin
    rstn = 1'b0;
    en = 1'b0;
    wk = 1'b0;
    rx_ready = 1'b0;
    wdata = 8'h00;
    bs = 3'h0;
    bv = 1'b0;
    {wc, wt, sw, wtb, wcb} = 5'h00;
    repeat (2) @(posedge mclk);
    #1;
    rstn = 1'b1;
    t_regs;
    t_cond;
    t_tx;
    t_busy;
    t_fifo;
    print_verdict;
  end
endmodule
bind serial_bus_handshake_control sbi_props props_u (.mclk(mclk), .rstn(rstn),
  .channel_enable(channel_enable), .wakeup_match_en(wakeup_match_en),
  .serial_clock_pin(serial_clock_pin), .serial_data_line_a_in(serial_data_line_a_in),
  .serial_data_line_a_oe(serial_data_line_a_oe), .wdata(wdata), .ctrl_wr_byte(ctrl_wr_byte),
  .ctrl_rdata(ctrl_rdata), .timing_wr_byte(timing_wr_byte), .timing_rdata(timing_rdata),
  .transfer_irq_flag(transfer_irq_flag));
`default_nettype wire
